/* File: ascii_sensor_poller_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ascii_sensor_poller_tb import asp_pkg::*;;
	localparam int BIT = 8;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, rxd, txd, irq, got_stb;
	logic [7:0] got_byte, b;
	logic [15:0] n_got;
	logic [64:0] nt;
	logic [64:0] exp_q[$];
	logic [7:0] exp_b[$];
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	integer seed = 32'h3C627CE2;
	string rep[4] = '{"1,000.25;-3\r\n", "1.234,5;7\003", "9\00242;1.5\r\n", "\0028;0,25\003"};
	logic [31:0] v0[4] = '{32'h200186B9, 32'h10003039, 32'h0000002A, 32'h00000008};
	logic [31:0] v1[4] = '{32'h80000003, 32'h00000007, 32'h1000000F, 32'h20000019};
	always #10 pclk = ~pclk;
	asp_poller #(.MS_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sensor_rxd(rxd), .sensor_txd(txd), .irq(irq));
	asp_sensor_model #(.BAUD(BIT)) i_sen (.pclk(pclk), .line_in(txd), .line_out(rxd),
		.got_stb(got_stb), .got_byte(got_byte), .n_got(n_got));
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask : check
	task automatic test_done;
		if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	// read data and sent bytes against the oldest note; hang guard
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready && !pwrite) begin
			nt = exp_q.pop_front();
			check("prdata", nt[31:0], prdata & nt[63:32]);
			check("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
		end
		if (got_stb === 1'b1) check("txbyte", exp_b.size() > 0 ? exp_b.pop_front() : 8'hXX, got_byte);
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	// entered just after a rising edge, leaves one edge after release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
		input logic err = 1'b0);
		exp_q.push_back({err, m, e});
		apb(1'b0, a, $random(seed));
	endtask : rd
	task automatic load(input string s);
		foreach (s[i]) wr(A_CDAT, {24'h0, s[i]});
	endtask : load
	task automatic irq_is(input logic v);
		repeat (2) @(negedge pclk);
		check("irq", {31'h0, v}, {31'h0, irq});
		@(posedge pclk);
	endtask : irq_is
	// one measurement; earlier attempts get a partial reply that stalls
	task automatic meas(input string r, input string part, input int tries);
		logic [15:0] k;
		// let earlier command bytes land first, so k counts only this command
		while (exp_b.size() > 0) @(posedge pclk);
		k = n_got + 16'h2;
		repeat (tries) begin
			exp_b.push_back(8'h3F);
			exp_b.push_back(8'h0D);
		end
		wr(A_GO, 32'h1);
		for (int t = 1; t <= tries; t++) begin
			while (n_got < k) @(posedge pclk);
			i_sen.send(t < tries ? part : r, 130 + ($random(seed) & 63));
			k = k + 16'h2;
		end
		while (irq !== 1'b1) @(posedge pclk);
	endtask : meas
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values and refused places
		rd(A_CTRL, 32'h0);
		rd(A_BAUD, 32'h1458);
		rd(A_WARM, 32'h3E8);
		rd(A_CTO, 32'h0);
		rd(A_FTO, 32'h3E8);
		rd(A_GO, 32'h0);
		rd(8'h60, 32'h0, '1, 1'b1);
		wr(A_BAUD, 32'(BIT));
		wr(A_CTO, 32'hC);
		wr(A_MASK, 32'h8);
		wr(A_CADR, 32'h0);
		load("I\\n");
		wr(A_ILEN, 32'h3);
		exp_b.push_back(8'h49);
		exp_b.push_back(8'h0A);
		wr(A_CADR, 32'h200);
		load("\\x3F\\r");
		wr(A_MLEN, 32'h6);
		while (irq !== 1'b1) @(posedge pclk);
		rd(A_STAT, 32'h8);
		wr(A_STAT, 32'hF);
		wr(A_MASK, 32'h3);
		wr(A_DLM0, 32'h4233785C);
		// every framing mode, both number formats
		for (int m = 0; m < 4; m++) begin
			wr(A_CTRL, 32'(m | ((m & 1) << 2)));
			meas(rep[m], "", 1);
			rd(A_VAL0, v0[m]);
			rd(A_VAL1, v1[m]);
			rd(A_INFO, 32'h43);
			rd(A_STAT, 32'h1);
			wr(A_STAT, 32'hF);
		end
		// retry saves a stalled reply, then both attempts stall
		wr(A_CTRL, 32'h8);
		meas("7\r\n", "5;6", 2);
		rd(A_VAL0, 32'h7);
		rd(A_STAT, 32'h1, 32'h3);
		wr(A_STAT, 32'hF);
		meas("5", "5", 2);
		for (int v = 0; v < 4; v++) rd(A_VAL0 + 8'(4 * v), 32'h80000000);
		rd(A_STAT, 32'h6, 32'h7);
		wr(A_MASK, 32'h0);
		irq_is(1'b0);
		wr(A_MASK, 32'h3);
		irq_is(1'b1);
		wr(A_STAT, 32'hF);
		irq_is(1'b0);
		// script path sends a raw byte
		wr(A_CTRL, 32'h10);
		b = 8'($random(seed));
		exp_b.push_back(b);
		wr(A_TXD, {24'h0, b});
		while (exp_b.size() > 0) @(posedge pclk);
		repeat (20) @(posedge pclk);
		test_done();
	end
endmodule : ascii_sensor_poller_tb
`default_nettype wire

/* File: asp_cmd_mem.sv */
// Behaviour
// [R1] after power-on the poller waits the warmup time and only then sends the init command.
// [R2] in CR/LF framing a reply ends on a carriage return directly followed by a line feed.
// [R3] in ETX framing a reply ends on a single end-of-text character.
// [R4] in STX+CR/LF framing a reply opens with start-of-text and ends on CR then LF.
// [R5] in STX+ETX framing a reply opens with start-of-text and ends on end-of-text.
// [R6] a gap between two received characters longer than the character timeout is an error, 0 disables it.
// [R7] gap monitoring starts only after the first reply character has arrived.
// [R8] the reply is split into values at any of up to ten configured delimiters.
// [R9] delimiters may be written with backslash escapes including \xhh, which use up input space.
// [R10] in the first number format a comma groups thousands and a period is the decimal point.
// [R11] in the second number format a period groups thousands and a comma is the decimal point.
// [R12] at each measurement the measurement command of 0 to 512 characters is sent to the sensor.
// [R13] init and measurement commands have their backslash escapes expanded to single bytes before sending.
// [R14] in script mode the built-in command generator is bypassed and the script supplies the commands.
// [R15] with retry on, a failed request is sent once more and only a second failure is an error.
// [R16] when the last attempt fails every value channel of this port takes the open-loop error value.
// [R17] on a character timeout the partial frame is dropped and no value is updated from it.
`timescale 1ns/1ns
`default_nettype none
package asp_pkg;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00, A_GO = 8'h04, A_STAT = 8'h08, A_MASK = 8'h0C;
	localparam logic [7:0] A_BAUD = 8'h10, A_WARM = 8'h14, A_CTO = 8'h18, A_FTO = 8'h1C;
	localparam logic [7:0] A_ILEN = 8'h20, A_MLEN = 8'h24, A_CADR = 8'h28, A_CDAT = 8'h2C;
	localparam logic [7:0] A_DLM0 = 8'h30, A_DLM1 = 8'h34, A_DLM2 = 8'h38, A_TXD = 8'h3C;
	localparam logic [7:0] A_INFO = 8'h40, A_VAL0 = 8'h50, A_VAL1 = 8'h54, A_VAL3 = 8'h5C;
	// control fields
	localparam int F_MODE = 0, F_FMT = 2, F_RETRY = 3, F_SCRIPT = 4;
	// status bits
	localparam int ST_DONE = 0, ST_ERR = 1, ST_CTO = 2, ST_INIT = 3;
	// reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [15:0] BAUD_RST = 16'h1458;
	localparam logic [15:0] WARM_RST = 16'h03E8;
	localparam logic [15:0] CTO_RST = 16'h0000;
	localparam logic [15:0] FTO_RST = 16'h03E8;
	// command store layout
	localparam logic [9:0] MEAS_BASE = 10'h200;
	localparam logic [9:0] CMD_MAX = 10'h200;
	localparam logic [9:0] DLM_END = 10'h00C;
	localparam int N_DLM = 10, DLM_RAW = 12, N_VAL = 4;
	// timing
	localparam int CLK_NS = 20;
	localparam int MS_NS = 1000000;
	localparam logic [3:0] UART_LAST = 4'h9;
	// characters
	localparam logic [7:0] C_STX = 8'h02, C_ETX = 8'h03, C_CR = 8'h0D, C_LF = 8'h0A;
	localparam logic [7:0] C_BSL = 8'h5C, C_X = 8'h78, C_COMMA = 8'h2C, C_DOT = 8'h2E;
	localparam logic [7:0] C_MINUS = 8'h2D, C_ZERO = 8'h30, C_NINE = 8'h39;
	localparam logic [31:0] OPEN_LOOP_ERROR_VALUE = 32'h80000000;
	typedef enum logic [1:0] {
		FM_CRLF = 2'h0,
		FM_ETX = 2'h1,
		FM_STX_CRLF = 2'h2,
		FM_STX_ETX = 2'h3
	} asp_frame_t;
	typedef enum logic [2:0] {
		S_WARM = 3'h0,
		S_INIT = 3'h1,
		S_IDLE = 3'h3,
		S_MEAS = 3'h2,
		S_WAIT = 3'h6,
		S_DLM = 3'h7
	} asp_seq_t;
	// single-letter escape after a backslash
	function automatic logic [7:0] asp_esc(input logic [7:0] c);
		case (c)
			8'h61: asp_esc = 8'h07;
			8'h62: asp_esc = 8'h08;
			8'h66: asp_esc = 8'h0C;
			8'h6E: asp_esc = 8'h0A;
			8'h72: asp_esc = 8'h0D;
			8'h74: asp_esc = 8'h09;
			8'h76: asp_esc = 8'h0B;
			default: asp_esc = c;
		endcase
	endfunction : asp_esc
	function automatic logic [3:0] asp_hex(input logic [7:0] c);
		if (c >= 8'h61) asp_hex = 4'(c - 8'h57);
		else if (c >= 8'h41) asp_hex = 4'(c - 8'h37);
		else asp_hex = 4'(c - C_ZERO);
	endfunction : asp_hex
endpackage : asp_pkg

// byte store for both commands, registered read port
module asp_cmd_mem #(
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	input wire logic pclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];
	if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
		$error("asp_cmd_mem: depth does not fit address width");
	end
	always_ff @(posedge pclk) begin
		if (we) mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule : asp_cmd_mem
`default_nettype wire

/* File: asp_poller.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_poller import asp_pkg::*; #(
	parameter int MS_CYCLES = MS_NS / CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sensor_rxd,
	output logic sensor_txd,
	output logic irq
);
	if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_chk
		$error("asp_poller: MS_CYCLES out of range");
	end
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic [4:0] ctrl;
		logic [3:0] stat;
		logic [3:0] mask;
		logic [15:0] baud;
		logic [15:0] warm;
		logic [15:0] cto;
		logic [15:0] fto;
		logic [9:0] ilen;
		logic [9:0] mlen;
		logic [9:0] cadr;
		logic [DLM_RAW-1:0][7:0] dlm_raw;
		logic dlm_pend;
		logic go_pend;
		logic txd_pend;
		logic [7:0] txd_byte;
		asp_seq_t st;
		logic [9:0] ptr;
		logic [9:0] pend;
		logic fetch;
		logic [1:0] esc;
		logic [3:0] hex_hi;
		logic again;
		logic [N_DLM-1:0][7:0] dlm;
		logic [3:0] dlm_n;
		logic tx_q;
		logic tx_busy;
		logic [8:0] tx_sh;
		logic [3:0] tx_bits;
		logic [15:0] tx_cnt;
		logic rx_s1;
		logic rx_s2;
		logic rx_busy;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [7:0] rx_sh;
		logic [15:0] ms_cnt;
		logic [15:0] ftm;
		logic [15:0] ctm;
		logic got_first;
		logic in_frame;
		logic prev_cr;
		logic [27:0] mag;
		logic [2:0] dec;
		logic neg;
		logic dp;
		logic has;
		logic [2:0] idx;
		logic [N_VAL-1:0][31:0] stage;
		logic [N_VAL-1:0][31:0] val;
	} asp_regs_t;

	asp_regs_t q, d;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic ms_tick, setup, acc, wr, rx_done, tx_load, emit, taken, hit, fend, fail, cto_hit;
	logic [3:0] ev, w1c;
	logic [7:0] sb, eb, rb, tx_byte, dp_c, grp_c;
	logic [31:0] rd;

	// command store, written one byte per access through the data port
	assign mem_we = psel && penable && q.pready && pwrite && paddr == A_CDAT;
	asp_cmd_mem #(.DEPTH(1024), .AW(10)) u_mem (
		.pclk(pclk),
		.we(mem_we),
		.waddr(q.cadr),
		.wdata(pwdata[7:0]),
		.raddr(q.ptr),
		.rdata(mem_rdata)
	);

	always_comb begin
		d = q;
		ev = 4'h0;
		w1c = 4'h0;
		rx_done = 1'b0;
		tx_load = 1'b0;
		tx_byte = 8'h00;
		emit = 1'b0;
		taken = 1'b0;
		hit = 1'b0;
		fend = 1'b0;
		fail = 1'b0;
		cto_hit = 1'b0;
		eb = 8'h00;
		rb = q.rx_sh;
		rd = 32'h00000000;
		setup = psel && !penable;
		acc = psel && penable && q.pready;
		wr = acc && pwrite && !q.pslverr;
		ms_tick = q.ms_cnt == MS_LAST;
		// number format picks which of comma and period is the decimal point
		dp_c = q.ctrl[F_FMT] ? C_COMMA : C_DOT; // R10 R11
		grp_c = q.ctrl[F_FMT] ? C_DOT : C_COMMA; // R10 R11
		sb = (q.st == S_DLM) ? q.dlm_raw[q.ptr[3:0]] : mem_rdata;
		d.ms_cnt = ms_tick ? 16'h0000 : q.ms_cnt + 16'h0001;

		// apb read mux, answered in the access phase without wait states
		unique case (paddr)
			A_CTRL: rd = {27'h0, q.ctrl};
			A_STAT: rd = {28'h0, q.stat};
			A_MASK: rd = {28'h0, q.mask};
			A_BAUD: rd = {16'h0, q.baud};
			A_WARM: rd = {16'h0, q.warm};
			A_CTO: rd = {16'h0, q.cto};
			A_FTO: rd = {16'h0, q.fto};
			A_ILEN: rd = {22'h0, q.ilen};
			A_MLEN: rd = {22'h0, q.mlen};
			A_CADR: rd = {22'h0, q.cadr};
			A_DLM0: rd = q.dlm_raw[3:0];
			A_DLM1: rd = q.dlm_raw[7:4];
			A_DLM2: rd = q.dlm_raw[11:8];
			A_INFO: rd = {22'h0, q.dlm_n, q.again, q.tx_busy, q.rx_busy, q.st};
			A_GO, A_CDAT, A_TXD: rd = 32'h00000000;
			default: rd = (paddr >= A_VAL0 && paddr <= A_VAL3 && paddr[1:0] == 2'h0) ?
				q.val[paddr[3:2]] : 32'h00000000;
		endcase
		d.pready = setup;
		if (setup) begin
			d.prdata = rd;
			d.pslverr = !(paddr <= A_INFO && paddr[1:0] == 2'h0) &&
				!(paddr >= A_VAL0 && paddr <= A_VAL3 && paddr[1:0] == 2'h0);
		end

		// register writes take effect at the access edge
		if (wr) begin
			unique case (paddr)
				A_CTRL: d.ctrl = pwdata[4:0];
				A_GO: d.go_pend = q.go_pend | pwdata[0];
				A_STAT: w1c = pwdata[3:0];
				A_MASK: d.mask = pwdata[3:0];
				A_BAUD: d.baud = pwdata[15:0];
				A_WARM: d.warm = pwdata[15:0];
				A_CTO: d.cto = pwdata[15:0];
				A_FTO: d.fto = pwdata[15:0];
				// longer commands are clipped to their half of the store
				A_ILEN: d.ilen = (pwdata[9:0] > CMD_MAX) ? CMD_MAX : pwdata[9:0];
				A_MLEN: d.mlen = (pwdata[9:0] > CMD_MAX) ? CMD_MAX : pwdata[9:0]; // R12
				A_CADR: d.cadr = pwdata[9:0];
				A_CDAT: d.cadr = q.cadr + 10'h001;
				A_DLM0: begin d.dlm_raw[3:0] = pwdata; d.dlm_pend = 1'b1; end
				A_DLM1: begin d.dlm_raw[7:4] = pwdata; d.dlm_pend = 1'b1; end
				A_DLM2: begin d.dlm_raw[11:8] = pwdata; d.dlm_pend = 1'b1; end
				A_TXD: begin d.txd_byte = pwdata[7:0]; d.txd_pend = 1'b1; end
				default: ;
			endcase
		end

		// uart transmitter, 8 data bits, one stop bit
		if (q.tx_busy) begin
			if (q.tx_cnt != 16'h0000) d.tx_cnt = q.tx_cnt - 16'h0001;
			else begin
				d.tx_cnt = q.baud - 16'h0001;
				d.tx_bits = q.tx_bits + 4'h1;
				if (q.tx_bits == UART_LAST) d.tx_busy = 1'b0;
				else begin
					d.tx_q = q.tx_sh[0];
					d.tx_sh = {1'b1, q.tx_sh[8:1]};
				end
			end
		end

		// uart receiver, samples each bit in its middle
		d.rx_s1 = sensor_rxd;
		d.rx_s2 = q.rx_s1;
		if (!q.rx_busy) begin
			if (!q.rx_s2) begin
				d.rx_busy = 1'b1;
				d.rx_cnt = {1'b0, q.baud[15:1]};
				d.rx_bits = 4'h0;
			end
		end else if (q.rx_cnt != 16'h0000) d.rx_cnt = q.rx_cnt - 16'h0001;
		else begin
			d.rx_cnt = q.baud - 16'h0001;
			d.rx_bits = q.rx_bits + 4'h1;
			if (q.rx_bits == 4'h0) d.rx_busy = !q.rx_s2; // glitch, not a start bit
			else if (q.rx_bits == UART_LAST) begin
				d.rx_busy = 1'b0;
				rx_done = q.rx_s2; // a bad stop bit drops the character
			end else d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
		end

		// escape expander shared by both commands and the delimiter list
		if ((q.st == S_INIT || q.st == S_MEAS || q.st == S_DLM) && q.ptr != q.pend) begin
			if (!q.fetch) d.fetch = 1'b1; // store read takes one cycle
			else begin
				unique case (q.esc)
					2'h0: begin
						if (sb == C_BSL) d.esc = 2'h1; // R9 R13
						else begin emit = 1'b1; eb = sb; end
					end
					2'h1: begin
						if (sb == C_X) d.esc = 2'h2; // R9 R13
						else begin emit = 1'b1; eb = asp_esc(sb); d.esc = 2'h0; end
					end
					2'h2: begin d.hex_hi = asp_hex(sb); d.esc = 2'h3; end
					2'h3: begin emit = 1'b1; eb = {q.hex_hi, asp_hex(sb)}; d.esc = 2'h0; end
				endcase
				// unused raw delimiter bytes are zero and are skipped
				if (q.st == S_DLM) begin
					taken = 1'b1;
					if (emit && eb != 8'h00 && q.dlm_n < 4'(N_DLM)) begin
						d.dlm[q.dlm_n] = eb; // R8 R9
						d.dlm_n = q.dlm_n + 4'h1;
					end
				end else if (!emit) taken = 1'b1;
				else if (!q.tx_busy) begin
					taken = 1'b1;
					tx_load = 1'b1;
					tx_byte = eb; // R13
				end
				if (taken) begin
					d.ptr = q.ptr + 10'h001;
					d.fetch = 1'b0;
				end else d.esc = q.esc; // hold decode state while the line is busy
			end
		end else if (q.st == S_IDLE && q.txd_pend && !q.tx_busy) begin
			// bytes pushed by the script go out unchanged
			tx_load = 1'b1;
			tx_byte = q.txd_byte;
			d.txd_pend = 1'b0;
		end
		if (tx_load) begin
			d.tx_busy = 1'b1;
			d.tx_q = 1'b0;
			d.tx_sh = {1'b1, tx_byte};
			d.tx_cnt = q.baud - 16'h0001;
			d.tx_bits = 4'h0;
		end

		// reply framing and number parsing
		if (q.st == S_WAIT) begin
			if (ms_tick) d.ftm = q.ftm + 16'h0001;
			if (ms_tick && q.got_first) d.ctm = q.ctm + 16'h0001; // R7
			if (rx_done) begin
				d.got_first = 1'b1; // R7
				d.ctm = 16'h0000; // R6
				for (int i = 0; i < N_DLM; i++) begin
					if (4'(i) < q.dlm_n && q.dlm[i] == rb) hit = 1'b1; // R8
				end
				if (q.ctrl[F_MODE+1] && !q.in_frame) d.in_frame = rb == C_STX; // R4 R5
				else begin
					d.in_frame = 1'b1;
					d.prev_cr = rb == C_CR;
					if (q.ctrl[F_MODE]) fend = rb == C_ETX; // R3 R5
					else fend = q.prev_cr && rb == C_LF; // R2 R4
					if (fend || hit) begin
						// each field becomes sign, decimal places and magnitude
						if (q.has && q.idx < 3'(N_VAL)) begin
							d.stage[q.idx[1:0]] = {q.neg, q.dec, q.mag};
							d.idx = q.idx + 3'h1;
						end
						d.mag = 28'h0;
						d.dec = 3'h0;
						d.neg = 1'b0;
						d.dp = 1'b0;
						d.has = 1'b0;
					end else if (rb >= C_ZERO && rb <= C_NINE) begin
						d.mag = 28'(q.mag * 28'h000000A + 28'(rb - C_ZERO));
						d.has = 1'b1;
						if (q.dp && q.dec != 3'h7) d.dec = q.dec + 3'h1;
					end else if (rb == dp_c) d.dp = 1'b1; // R10 R11
					else if (rb == C_MINUS) d.neg = 1'b1;
					// grouping marks and any other character are skipped
				end
			end
			cto_hit = q.cto != 16'h0000 && q.got_first && q.ctm > q.cto; // R6
			fail = !fend && (cto_hit || (q.fto != 16'h0000 && q.ftm >= q.fto));
		end

		// sequencer
		unique case (q.st)
			S_WARM: begin
				if (ms_tick) d.ftm = q.ftm + 16'h0001;
				if (q.ftm >= q.warm) begin // R1
					d.ptr = 10'h000;
					d.pend = q.ilen;
					d.fetch = 1'b0;
					d.esc = 2'h0;
					d.st = q.ctrl[F_SCRIPT] ? S_IDLE : S_INIT; // R1 R14
				end
			end
			S_INIT: if (q.ptr == q.pend) begin
				d.st = S_IDLE;
				ev[ST_INIT] = 1'b1;
			end
			S_IDLE: begin
				d.ptr = MEAS_BASE;
				d.pend = MEAS_BASE + q.mlen;
				d.fetch = 1'b0;
				d.esc = 2'h0;
				if (q.dlm_pend) begin
					d.dlm_pend = 1'b0;
					d.ptr = 10'h000;
					d.pend = DLM_END;
					d.dlm_n = 4'h0;
					d.st = S_DLM;
				end else if (q.go_pend) begin
					d.go_pend = 1'b0;
					d.again = 1'b0;
					d.st = S_MEAS;
					// the script drives the line itself; only the reply is watched
					if (q.ctrl[F_SCRIPT]) d.pend = MEAS_BASE; // R14
				end
			end
			S_DLM: if (q.ptr == q.pend) d.st = S_IDLE;
			S_MEAS: if (q.ptr == q.pend && !q.tx_busy) begin // R12
				d.st = S_WAIT;
				d.ftm = 16'h0000;
				d.ctm = 16'h0000;
				d.got_first = 1'b0;
				d.in_frame = 1'b0;
				d.prev_cr = 1'b0;
				d.mag = 28'h0;
				d.dec = 3'h0;
				d.neg = 1'b0;
				d.dp = 1'b0;
				d.has = 1'b0;
				d.idx = 3'h0;
				d.stage = '0;
			end
			S_WAIT: begin
				if (fend) begin
					d.val = d.stage;
					ev[ST_DONE] = 1'b1;
					d.st = S_IDLE;
				end else if (fail) begin
					// partial frame is dropped, stage never reaches the values
					ev[ST_CTO] = cto_hit; // R17
					if (q.ctrl[F_RETRY] && !q.again) begin
						d.again = 1'b1; // R15
						d.ptr = MEAS_BASE;
						d.pend = q.ctrl[F_SCRIPT] ? MEAS_BASE : MEAS_BASE + q.mlen;
						d.fetch = 1'b0;
						d.esc = 2'h0;
						d.st = S_MEAS;
					end else begin
						ev[ST_ERR] = 1'b1; // R15
						for (int i = 0; i < N_VAL; i++) d.val[i] = OPEN_LOOP_ERROR_VALUE; // R16
						d.st = S_IDLE;
					end
				end
			end
		endcase

		// sticky status, a new event wins over a clear in the same cycle
		d.stat = (q.stat & ~w1c) | ev;
		d.irq = |(d.stat & d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.baud <= BAUD_RST;
			q.warm <= WARM_RST;
			q.cto <= CTO_RST;
			q.fto <= FTO_RST;
			q.st <= S_WARM;
			q.tx_q <= 1'b1;
			q.rx_s1 <= 1'b1;
			q.rx_s2 <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign sensor_txd = q.tx_q;
	assign irq = q.irq;
endmodule : asp_poller
`default_nettype wire

/* File: asp_poller_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_poller_chk import asp_pkg::*; #(
	parameter int MS_CYCLES = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sensor_rxd,
	input wire logic sensor_txd,
	input wire logic irq
);
	// one tick of slack before and four ticks after the warmup count
	localparam int QUIET = (int'(WARM_RST) - 1) * MS_CYCLES;
	localparam int DUE = (int'(WARM_RST) + 4) * MS_CYCLES;
	logic [31:0] cnt_q;
	logic fell_q;
	logic scr_q;
	logic wr;
	logic clr;
	assign wr = psel && penable && pready && pwrite;
	assign clr = wr && (paddr == A_STAT || paddr == A_MASK);
	// age since reset, first line activity, shadow of the script bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			fell_q <= 1'b0;
			scr_q <= 1'b0;
		end else begin
			if (cnt_q <= 32'(DUE)) cnt_q <= cnt_q + 32'h1; // saturates, no wrap
			if (!sensor_txd) fell_q <= 1'b1;
			if (wr && paddr == A_CTRL) scr_q <= pwdata[F_SCRIPT];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	warm_quiet_a: assert property (cnt_q < 32'(QUIET) |-> sensor_txd)
		else $error("command line active during warmup");
	init_due_a: assert property (cnt_q == 32'(DUE) |-> fell_q)
		else $error("init command not started after warmup");
	go_sends_a: assert property (wr && paddr == A_GO && pwdata[0] && !scr_q |-> ##[1:40] !sensor_txd)
		else $error("measurement command not started");
	tx_script_a: assert property (wr && paddr == A_TXD && scr_q |-> ##[1:40] !sensor_txd)
		else $error("script byte not sent");
	ready_once_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	bad_addr_a: assert property (psel && !penable && paddr > A_VAL3 |=> pslverr && prdata == 32'h0)
		else $error("unmapped address not refused");
	go_zero_a: assert property (psel && !penable && !pwrite && paddr == A_GO |=> prdata == 32'h0)
		else $error("go register reads nonzero");
	irq_fall_a: assert property ($fell(irq) |-> $past(clr, 1) || $past(clr, 2))
		else $error("interrupt dropped without a clear");
endmodule : asp_poller_chk
bind asp_poller asp_poller_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sensor_rxd(sensor_rxd),
	.sensor_txd(sensor_txd), .irq(irq));
`default_nettype wire

/* File: asp_sensor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_sensor_model #(
	parameter int BAUD = 8
) (
	input wire logic pclk,
	input wire logic line_in,
	output logic line_out,
	output logic got_stb,
	output logic [7:0] got_byte,
	output logic [15:0] n_got
);
	initial begin
		line_out = 1'b1;
		got_stb = 1'b0;
		got_byte = 8'h00;
		n_got = 16'h0;
	end
	// receiver, lsb first, sampled mid-bit
	always begin
		@(negedge line_in);
		repeat (BAUD / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BAUD) @(posedge pclk);
			got_byte[i] = line_in;
		end
		repeat (BAUD) @(posedge pclk);
		n_got <= n_got + 16'h1;
		got_stb <= 1'b1;
		@(posedge pclk);
		got_stb <= 1'b0;
	end
	// one 8N1 character; line idles high between characters
	task automatic put(input logic [7:0] b);
		line_out <= 1'b0;
		repeat (BAUD) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			line_out <= b[i];
			repeat (BAUD) @(posedge pclk);
		end
		line_out <= 1'b1;
		repeat (BAUD) @(posedge pclk);
	endtask : put
	// reply frame as given, framing characters included
	task automatic send(input string s, input int lead);
		repeat (lead) @(posedge pclk);
		foreach (s[k]) put(s[k]);
	endtask : send
endmodule : asp_sensor_model
`default_nettype wire
